// *** include/dspid_consts.svh ***
`ifndef DSPID_CONSTS_SVH
`define DSPID_CONSTS_SVH
// register word addresses on the plain register port
`define DSPID_REG_CTRL 4'h0
`define DSPID_REG_PAGE 4'h1
`define DSPID_REG_STAT 4'h2
`define DSPID_REG_RPT 4'h3
`define DSPID_REG_LAST 4'h4
// reset values
`define DSPID_CTRL_RST 1'b1
`define DSPID_PAGE_RST 9'h000
`define DSPID_RPT_RST 8'h00
// instruction field positions
`define DSPID_F_SHIFT 11:8
`define DSPID_F_XSHIFT 10:8
`define DSPID_F_AUX 10:8
`define DSPID_F_PA 11:8
`define DSPID_F_IND 7
`define DSPID_F_DADDR 6:0
`define DSPID_F_CMP 1:0
`define DSPID_F_PM 1:0
`define DSPID_F_ARP 2:0
`define DSPID_F_FMT 0
`define DSPID_F_DP 8:0
`define DSPID_F_HI 15:8
// opcode patterns
`define DSPID_P_ABS 16'b1100_1110_0001_1011
`define DSPID_P_ADD 16'b0000_????_????_????
`define DSPID_P_LALK 16'b1101_????_0000_0001
`define DSPID_P_ACC_ADD_LONG_IMM 16'b1101_????_0000_0010
`define DSPID_P_SBLK 16'b1101_????_0000_0011
`define DSPID_P_ANDK 16'b1101_????_0000_0100
`define DSPID_P_ORK 16'b1101_????_0000_0101
`define DSPID_P_XORK 16'b1101_????_0000_0110
`define DSPID_P_STH 16'b0110_1???_????_????
`define DSPID_P_STL 16'b0110_0???_????_????
`define DSPID_P_LDAR 16'b0011_0???_????_????
`define DSPID_P_STAR 16'b0111_0???_????_????
`define DSPID_P_LDARP 16'b0101_0101_1000_1???
`define DSPID_P_CMP 16'b1100_1110_0101_00??
`define DSPID_P_SPM 16'b1100_1110_0000_10??
`define DSPID_P_IN 16'b1000_????_????_????
`define DSPID_P_OUT 16'b1110_????_????_????
`define DSPID_P_BR 16'b1111_1111_1???_????
`define DSPID_P_CALLD 16'b1111_1110_1???_????
`define DSPID_P_BCND 16'b1111_????_1???_????
`define DSPID_P_BCRY 16'b0101_111?_1???_????
`define DSPID_P_BRANCH_VIA_ACC 16'b1100_1110_0010_0101
`define DSPID_P_CALL_VIA_ACC 16'b1100_1110_0010_0100
`define DSPID_P_RET 16'b1100_1110_0010_0110
`define DSPID_P_MULT_ACC_MOVE 16'b0101_1100_????_????
`define DSPID_P_MULT_ADD_PREV 16'b0011_1010_????_????
`define DSPID_P_SERIAL_FORMAT_SET 16'b1100_1110_0000_111?
`define DSPID_P_TXC 16'b1100_1110_0010_0000
`define DSPID_P_TXS 16'b1100_1110_0010_0001
`define DSPID_P_FSC 16'b1100_1110_0011_0110
`define DSPID_P_FSS 16'b1100_1110_0011_0111
`define DSPID_P_BLOCK_MOVE_PROG_TO_DATA 16'b1111_1100_????_????
`define DSPID_P_PAGE_PTR_LOAD_IMM 16'b1100_100?_????_????
`define DSPID_P_ACC_NORMALIZE 16'b1100_1110_1???_????
`define DSPID_P_ZERO_LOW_LOAD_HIGH 16'b0100_0000_????_????
`define DSPID_P_ZERO_LOW_LOAD_HIGH_ROUND 16'b0111_1011_????_????
`endif

// *** include/dspid_pkg.sv ***
package dspid_pkg;
  // operation handed to the datapath
  typedef enum logic [5:0] {
    DSPID_NOP, DSPID_ACC_MAGNITUDE, DSPID_ADD_SHIFT, DSPID_LOAD_LONG_IMM,
    DSPID_ACC_ADD_LONG_IMM, DSPID_SUB_LONG_IMM, DSPID_AND_LONG_IMM, DSPID_OR_LONG_IMM,
    DSPID_XOR_LONG_IMM, DSPID_STORE_ACC_UPPER, DSPID_STORE_ACC_LOWER, DSPID_LOAD_AUX,
    DSPID_STORE_AUX, DSPID_LOAD_AUX_POINTER, DSPID_AUX_COMPARE,
    DSPID_PRODUCT_SHIFT_MODE_SET, DSPID_PORT_IN, DSPID_PORT_OUT, DSPID_BRANCH,
    DSPID_CALL_DIRECT, DSPID_BRANCH_COND, DSPID_BRANCH_VIA_ACC, DSPID_CALL_VIA_ACC,
    DSPID_RETURN_OP, DSPID_MULT_ACC_MOVE, DSPID_MULT_ADD_PREV, DSPID_SERIAL_FORMAT_SET,
    DSPID_TX_MODE_SET, DSPID_TX_MODE_CLEAR, DSPID_FRAMESYNC_MODE_SET,
    DSPID_FRAMESYNC_MODE_CLEAR, DSPID_BLOCK_MOVE_PROG_TO_DATA, DSPID_PAGE_PTR_LOAD_IMM,
    DSPID_ACC_NORMALIZE, DSPID_ZERO_LOW_LOAD_HIGH, DSPID_ZERO_LOW_LOAD_HIGH_ROUND
  } dspid_op_e;
  // sequencer states, gray along idle -> second word -> repeat
  typedef enum logic [1:0] {
    DSPID_IDLE = 2'b00,
    DSPID_WAIT2 = 2'b01,
    DSPID_REPEAT = 2'b11
  } dspid_state_e;
endpackage

// *** hdl/dspid_decoder.sv ***
`include "dspid_consts.svh"
module dspid_decoder import dspid_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  input wire logic acc_zero,
  input wire logic acc_neg,
  input wire logic acc_ovf,
  input wire logic acc_carry,
  input wire logic acc_msb_equal,
  input wire logic [15:0] ar_cur_val,
  input wire logic [15:0] ar0_val,
  input wire logic bio_n_pin,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic op_valid,
  output dspid_op_e op_kind,
  output logic two_word,
  output logic fetch_second,
  output logic fetch_stall,
  output logic [3:0] shift_code,
  output logic [2:0] store_shift,
  output logic [2:0] aux_sel,
  output logic [1:0] cmp_mode,
  output logic [3:0] port_addr_field,
  output logic [15:0] imm_word,
  output logic [15:0] data_addr,
  output logic ind_mode,
  output logic [6:0] ind_ctrl,
  output logic pc_load,
  output logic [15:0] pc_target,
  output logic pc_from_acc,
  output logic push_return,
  output logic pop_return,
  output logic acc_normalize_shift,
  output logic [2:0] aux_reg_pointer,
  output logic [1:0] product_shift_mode,
  output logic serial_format,
  output logic tx_mode,
  output logic framesync_mode,
  output logic test_control_flag,
  output logic [8:0] page_ptr
);
  // opcode recognition; anything unlisted is a no-operation
  function automatic dspid_op_e decode_op(input logic [15:0] w);
    casez (w)
      `DSPID_P_ABS: decode_op = DSPID_ACC_MAGNITUDE;
      `DSPID_P_ADD: decode_op = DSPID_ADD_SHIFT;
      `DSPID_P_LALK: decode_op = DSPID_LOAD_LONG_IMM;
      `DSPID_P_ACC_ADD_LONG_IMM: decode_op = DSPID_ACC_ADD_LONG_IMM;
      `DSPID_P_SBLK: decode_op = DSPID_SUB_LONG_IMM;
      `DSPID_P_ANDK: decode_op = DSPID_AND_LONG_IMM;
      `DSPID_P_ORK: decode_op = DSPID_OR_LONG_IMM;
      `DSPID_P_XORK: decode_op = DSPID_XOR_LONG_IMM;
      `DSPID_P_STH: decode_op = DSPID_STORE_ACC_UPPER;
      `DSPID_P_STL: decode_op = DSPID_STORE_ACC_LOWER;
      `DSPID_P_LDAR: decode_op = DSPID_LOAD_AUX;
      `DSPID_P_STAR: decode_op = DSPID_STORE_AUX;
      `DSPID_P_LDARP: decode_op = DSPID_LOAD_AUX_POINTER;
      `DSPID_P_CMP: decode_op = DSPID_AUX_COMPARE;
      `DSPID_P_SPM: decode_op = DSPID_PRODUCT_SHIFT_MODE_SET;
      `DSPID_P_IN: decode_op = DSPID_PORT_IN;
      `DSPID_P_OUT: decode_op = DSPID_PORT_OUT;
      `DSPID_P_BR: decode_op = DSPID_BRANCH;
      `DSPID_P_CALLD: decode_op = DSPID_CALL_DIRECT;
      `DSPID_P_BLOCK_MOVE_PROG_TO_DATA: decode_op = DSPID_BLOCK_MOVE_PROG_TO_DATA;
      `DSPID_P_BCND: decode_op = (w[11:8] == 4'hd) ? DSPID_NOP : DSPID_BRANCH_COND;
      `DSPID_P_BCRY: decode_op = DSPID_BRANCH_COND;
      `DSPID_P_BRANCH_VIA_ACC: decode_op = DSPID_BRANCH_VIA_ACC;
      `DSPID_P_CALL_VIA_ACC: decode_op = DSPID_CALL_VIA_ACC;
      `DSPID_P_RET: decode_op = DSPID_RETURN_OP;
      `DSPID_P_MULT_ACC_MOVE: decode_op = DSPID_MULT_ACC_MOVE;
      `DSPID_P_MULT_ADD_PREV: decode_op = DSPID_MULT_ADD_PREV;
      `DSPID_P_SERIAL_FORMAT_SET: decode_op = DSPID_SERIAL_FORMAT_SET;
      `DSPID_P_TXC: decode_op = DSPID_TX_MODE_CLEAR;
      `DSPID_P_TXS: decode_op = DSPID_TX_MODE_SET;
      `DSPID_P_FSC: decode_op = DSPID_FRAMESYNC_MODE_CLEAR;
      `DSPID_P_FSS: decode_op = DSPID_FRAMESYNC_MODE_SET;
      `DSPID_P_PAGE_PTR_LOAD_IMM: decode_op = DSPID_PAGE_PTR_LOAD_IMM;
      `DSPID_P_ACC_NORMALIZE: decode_op = DSPID_ACC_NORMALIZE;
      `DSPID_P_ZERO_LOW_LOAD_HIGH: decode_op = DSPID_ZERO_LOW_LOAD_HIGH;
      `DSPID_P_ZERO_LOW_LOAD_HIGH_ROUND: decode_op = DSPID_ZERO_LOW_LOAD_HIGH_ROUND;
      default: decode_op = DSPID_NOP;
    endcase
  endfunction
  // two-word opcodes need their operand word before they issue
  function automatic logic is_two_word(input dspid_op_e op);
    case (op)
      DSPID_LOAD_LONG_IMM, DSPID_ACC_ADD_LONG_IMM, DSPID_SUB_LONG_IMM,
      DSPID_AND_LONG_IMM, DSPID_OR_LONG_IMM, DSPID_XOR_LONG_IMM,
      DSPID_BRANCH, DSPID_CALL_DIRECT, DSPID_BRANCH_COND,
      DSPID_MULT_ACC_MOVE, DSPID_BLOCK_MOVE_PROG_TO_DATA: is_two_word = 1'b1;
      default: is_two_word = 1'b0;
    endcase
  endfunction
  // branch condition selected by the high byte of the first word
  function automatic logic cond_met(input logic [7:0] hi, input logic z, input logic n,
    input logic v, input logic c, input logic tc, input logic bio_lo, input logic ar_nz);
    case (hi)
      8'hF0: cond_met = v;
      8'hF1: cond_met = !n && !z;
      8'hF2: cond_met = n || z;
      8'hF3: cond_met = n;
      8'hF4: cond_met = !n;
      8'hF5: cond_met = !z;
      8'hF6: cond_met = z;
      8'hF7: cond_met = !v;
      8'hF8: cond_met = !tc;
      8'hF9: cond_met = tc;
      8'hFA: cond_met = bio_lo;
      8'hFB: cond_met = ar_nz;
      8'h5E: cond_met = c;
      8'h5F: cond_met = !c;
      default: cond_met = 1'b0;
    endcase
  endfunction
  // aux compare under the two-bit mode, unsigned
  function automatic logic cmp_true(input logic [1:0] m, input logic [15:0] a,
                                    input logic [15:0] b);
    case (m)
      2'b00: cmp_true = (a == b);
      2'b01: cmp_true = (a < b);
      2'b10: cmp_true = (a > b);
      default: cmp_true = (a != b);
    endcase
  endfunction
  dspid_state_e state_q;
  logic [15:0] first_q, rdata_q, iss_word;
  logic [8:0] page_q;
  logic [7:0] rpt_q;
  logic [2:0] arp_q;
  logic [1:0] bio_sync_q, pm_q;
  logic ctrl_en_q, tc_q, fmt_q, txm_q, fsm_q;
  dspid_op_e new_op, pend_op, iss_op, exe_op;
  logic take_first, take_second, issue_now, exec_now;
  assign new_op = decode_op(instr_word);
  assign pend_op = decode_op(first_q);
  assign take_first = (state_q == DSPID_IDLE) && instr_valid && ctrl_en_q;
  assign take_second = (state_q == DSPID_WAIT2) && instr_valid;
  assign issue_now = (take_first && !is_two_word(new_op)) || take_second;
  assign iss_op = take_second ? pend_op : new_op;
  assign iss_word = take_second ? first_q : instr_word;
  assign exec_now = issue_now || (state_q == DSPID_REPEAT);
  assign exe_op = issue_now ? iss_op : op_kind;
  // branch-control pin synchroniser
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bio_sync_q <= 2'b11;
    end else begin
      bio_sync_q <= {bio_sync_q[0], bio_n_pin};
    end
  end
  // sequencer: first word, optional second word, repeats
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= DSPID_IDLE;
      first_q <= 16'h0000;
    end else begin
      unique case (state_q)
        DSPID_IDLE: begin
          if (take_first) begin
            first_q <= instr_word;
            if (is_two_word(new_op)) begin
              state_q <= DSPID_WAIT2;
            end else if (rpt_q != 8'h00) begin
              state_q <= DSPID_REPEAT;
            end
          end
        end
        DSPID_WAIT2: begin
          if (take_second) begin
            state_q <= (rpt_q != 8'h00) ? DSPID_REPEAT : DSPID_IDLE;
          end
        end
        DSPID_REPEAT: begin
          if (rpt_q == 8'h01) begin
            state_q <= DSPID_IDLE;
          end
        end
      endcase
    end
  end
  // fetch handshake flags toward the fetch unit
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fetch_second <= 1'b0;
      fetch_stall <= 1'b0;
    end else begin
      fetch_second <= take_first ? is_two_word(new_op) : (fetch_second && !take_second);
      if (issue_now && rpt_q != 8'h00) begin
        fetch_stall <= 1'b1;
      end else if (state_q == DSPID_REPEAT && rpt_q == 8'h01) begin
        fetch_stall <= 1'b0;
      end
    end
  end
  // repeat counter: software writes executions minus one
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rpt_q <= `DSPID_RPT_RST;
    end else if (state_q == DSPID_REPEAT) begin
      rpt_q <= rpt_q - 8'h01;
    end else if (reg_wr && reg_addr == `DSPID_REG_RPT) begin
      rpt_q <= reg_wdata[7:0];
    end
  end
  // issued operation and its operand fields
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      op_valid <= 1'b0;
      op_kind <= DSPID_NOP;
      two_word <= 1'b0;
      shift_code <= 4'h0;
      store_shift <= 3'h0;
      aux_sel <= 3'h0;
      cmp_mode <= 2'h0;
      port_addr_field <= 4'h0;
      imm_word <= 16'h0000;
      data_addr <= 16'h0000;
      ind_mode <= 1'b0;
      ind_ctrl <= 7'h00;
    end else begin
      op_valid <= exec_now;
      if (issue_now) begin
        op_kind <= iss_op;
        two_word <= take_second;
        shift_code <= iss_word[`DSPID_F_SHIFT];
        store_shift <= iss_word[`DSPID_F_XSHIFT];
        aux_sel <= (iss_op == DSPID_LOAD_AUX_POINTER) ? iss_word[`DSPID_F_ARP]
                                                      : iss_word[`DSPID_F_AUX];
        cmp_mode <= iss_word[`DSPID_F_CMP];
        port_addr_field <= iss_word[`DSPID_F_PA];
        imm_word <= take_second ? instr_word : 16'h0000;
        data_addr <= {page_q, iss_word[`DSPID_F_DADDR]};
        ind_mode <= iss_word[`DSPID_F_IND];
        ind_ctrl <= iss_word[`DSPID_F_DADDR];
      end
    end
  end
  // program-flow controls
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pc_load <= 1'b0;
      pc_target <= 16'h0000;
      pc_from_acc <= 1'b0;
      push_return <= 1'b0;
      pop_return <= 1'b0;
    end else begin
      pc_load <= 1'b0;
      pc_from_acc <= 1'b0;
      push_return <= 1'b0;
      pop_return <= 1'b0;
      if (issue_now) begin
        unique case (iss_op)
          DSPID_BRANCH: begin
            pc_load <= 1'b1;
            pc_target <= instr_word;
          end
          DSPID_CALL_DIRECT: begin
            pc_load <= 1'b1;
            pc_target <= instr_word;
            push_return <= 1'b1;
          end
          DSPID_BRANCH_COND: begin
            pc_load <= cond_met(first_q[`DSPID_F_HI], acc_zero, acc_neg, acc_ovf, acc_carry,
                                tc_q, !bio_sync_q[1], ar_cur_val != 16'h0000);
            pc_target <= instr_word;
          end
          DSPID_BRANCH_VIA_ACC: begin
            pc_load <= 1'b1;
            pc_from_acc <= 1'b1;
          end
          DSPID_CALL_VIA_ACC: begin
            pc_load <= 1'b1;
            pc_from_acc <= 1'b1;
            push_return <= 1'b1;
          end
          DSPID_RETURN_OP: begin
            pc_load <= 1'b1;
            pop_return <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end
  // normalize step: shift when top bits agree
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      acc_normalize_shift <= 1'b0;
    end else begin
      acc_normalize_shift <= exec_now && exe_op == DSPID_ACC_NORMALIZE && acc_msb_equal;
    end
  end
  // test/control flag from compare and normalize
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tc_q <= 1'b0;
    end else if (exec_now && exe_op == DSPID_AUX_COMPARE) begin
      tc_q <= cmp_true(issue_now ? iss_word[`DSPID_F_CMP] : cmp_mode,
                       ar_cur_val, ar0_val);
    end else if (exec_now && exe_op == DSPID_ACC_NORMALIZE) begin
      tc_q <= !acc_msb_equal;
    end
  end
  // page pointer: immediate load or software write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      page_q <= `DSPID_PAGE_RST;
    end else if (issue_now && iss_op == DSPID_PAGE_PTR_LOAD_IMM) begin
      page_q <= iss_word[`DSPID_F_DP];
    end else if (reg_wr && reg_addr == `DSPID_REG_PAGE) begin
      page_q <= reg_wdata[8:0];
    end
  end
  // pointer, product shift and serial mode bits
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      arp_q <= 3'h0;
      pm_q <= 2'h0;
      fmt_q <= 1'b0;
      txm_q <= 1'b0;
      fsm_q <= 1'b0;
    end else if (issue_now) begin
      unique case (iss_op)
        DSPID_LOAD_AUX_POINTER: arp_q <= iss_word[`DSPID_F_ARP];
        DSPID_PRODUCT_SHIFT_MODE_SET: pm_q <= iss_word[`DSPID_F_PM];
        DSPID_SERIAL_FORMAT_SET: fmt_q <= iss_word[`DSPID_F_FMT];
        DSPID_TX_MODE_SET: txm_q <= 1'b1;
        DSPID_TX_MODE_CLEAR: txm_q <= 1'b0;
        DSPID_FRAMESYNC_MODE_SET: fsm_q <= 1'b1;
        DSPID_FRAMESYNC_MODE_CLEAR: fsm_q <= 1'b0;
        default: ;
      endcase
    end
  end
  // control register: decode enable
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_en_q <= `DSPID_CTRL_RST;
    end else if (reg_wr && reg_addr == `DSPID_REG_CTRL) begin
      ctrl_en_q <= reg_wdata[0];
    end
  end
  // register read port, data one cycle after the strobe, else zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_q <= 16'h0000;
    end else begin
      case (reg_rd ? reg_addr : 4'hf) // idle cycles select an unmapped word
        `DSPID_REG_CTRL: rdata_q <= {15'h0000, ctrl_en_q};
        `DSPID_REG_PAGE: rdata_q <= {7'h00, page_q};
        `DSPID_REG_STAT: rdata_q <= {3'h0, state_q, fsm_q, txm_q, fmt_q, tc_q, pm_q,
                                     2'h0, arp_q};
        `DSPID_REG_RPT: rdata_q <= {8'h00, rpt_q};
        `DSPID_REG_LAST: rdata_q <= first_q;
        default: rdata_q <= 16'h0000;
      endcase
    end
  end
  assign reg_rdata = rdata_q;
  assign aux_reg_pointer = arp_q;
  assign product_shift_mode = pm_q;
  assign serial_format = fmt_q;
  assign tx_mode = txm_q;
  assign framesync_mode = fsm_q;
  assign test_control_flag = tc_q;
  assign page_ptr = page_q;
endmodule

// *** tb/dspid_decoder_checker.sv ***
module dspid_decoder_checker import dspid_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  input wire logic op_valid,
  input wire dspid_op_e op_kind,
  input wire logic two_word,
  input wire logic fetch_second,
  input wire logic fetch_stall,
  input wire logic [3:0] shift_code,
  input wire logic [3:0] port_addr_field,
  input wire logic [15:0] data_addr,
  input wire logic [8:0] page_ptr,
  input wire logic pc_load,
  input wire logic [15:0] pc_target,
  input wire logic pc_from_acc,
  input wire logic push_return,
  input wire logic pop_return
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] word_q;
  logic vld_q;
  logic one_w;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // word seen on the previous edge, the cause of this cycle's issue
  always_ff @(posedge clk_sys) begin
    word_q <= instr_word;
    vld_q <= instr_valid;
  end
  // a one-word issue straight from a taken word
  assign one_w = op_valid && vld_q && !two_word;
  a_magnitude_kind: assert property (one_w && word_q == 16'hce1b |->
    op_kind == DSPID_ACC_MAGNITUDE)
    else $error("magnitude opcode decoded wrongly");
  a_add_fields: assert property (one_w && word_q[15:12] == 4'h0 |->
    op_kind == DSPID_ADD_SHIFT && shift_code == word_q[11:8])
    else $error("add opcode or shift wrong");
  a_direct_addr: assert property (one_w && word_q[15:12] == 4'h0 |->
    data_addr == {page_ptr, word_q[6:0]})
    else $error("direct address wrong");
  a_port_in_field: assert property (one_w && word_q[15:12] == 4'h8 |->
    op_kind == DSPID_PORT_IN && port_addr_field == word_q[11:8])
    else $error("port input field wrong");
  a_branch_acc: assert property (one_w && word_q == 16'hce25 |-> pc_load && pc_from_acc)
    else $error("branch via accumulator wrong");
  a_call_acc: assert property (one_w && word_q == 16'hce24 |-> pc_load && push_return)
    else $error("call via accumulator wrong");
  a_return_pop: assert property (one_w && word_q == 16'hce26 |-> pc_load && pop_return)
    else $error("return does not pop");
  a_branch_target: assert property (op_valid && op_kind == DSPID_BRANCH |->
    pc_load && two_word && pc_target == word_q)
    else $error("branch target wrong");
  a_second_fetch: assert property (op_valid && two_word && vld_q |->
    $past(fetch_second) && !fetch_second)
    else $error("second fetch not flagged");
  a_repeat_stall: assert property (op_valid && !vld_q |-> $past(fetch_stall))
    else $error("repeat issue without stall");
  c_two_word: cover property (op_valid && two_word);
  c_call: cover property (pc_load && push_return);
  c_repeat: cover property (op_valid && fetch_stall);
endmodule
bind dspid_decoder dspid_decoder_checker i_chk (.clk_sys, .rst, .instr_word, .instr_valid,
  .op_valid, .op_kind, .two_word, .fetch_second, .fetch_stall, .shift_code, .port_addr_field,
  .data_addr, .page_ptr, .pc_load, .pc_target, .pc_from_acc, .push_return, .pop_return);

// *** tb/dspid_datapath_model.sv ***
module dspid_datapath_model (
  input wire logic clk_sys,
  input wire logic [31:0] acc_in,
  input wire logic ovf_in,
  input wire logic carry_in,
  output logic acc_zero,
  output logic acc_neg,
  output logic acc_ovf,
  output logic acc_carry,
  output logic acc_msb_equal
);
  timeunit 1ns;
  timeprecision 1ps;
  // flags follow the accumulator one cycle after it is loaded
  always_ff @(posedge clk_sys) begin
    acc_zero <= (acc_in == 32'h0000_0000);
    acc_neg <= acc_in[31];
    acc_ovf <= ovf_in;
    acc_carry <= carry_in;
    acc_msb_equal <= (acc_in[31] == acc_in[30]);
  end
endmodule

// *** tb/dsp_instruction_decoder_test.sv ***
module dsp_instruction_decoder_test import dspid_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [15:0] instr_word = 16'h0000;
  logic instr_valid = 1'b0;
  logic [31:0] acc_in = 32'h0000_0000;
  logic ovf_in = 1'b0;
  logic carry_in = 1'b0;
  logic [15:0] ar_cur_val = 16'h0000;
  logic [15:0] ar0_val = 16'h0000;
  logic bio_n_pin = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic acc_zero, acc_neg, acc_ovf, acc_carry, acc_msb_equal, op_valid, two_word;
  logic fetch_second, fetch_stall, ind_mode, pc_load, pc_from_acc, push_return, pop_return;
  logic acc_normalize_shift, serial_format, tx_mode, framesync_mode, test_control_flag;
  logic [15:0] reg_rdata, imm_word, data_addr, pc_target;
  logic [3:0] shift_code, port_addr_field;
  logic [2:0] store_shift, aux_sel, aux_reg_pointer;
  logic [1:0] cmp_mode, product_shift_mode;
  logic [6:0] ind_ctrl;
  logic [8:0] page_ptr;
  dspid_op_e op_kind;
  int failures = 0;
  int total_checks = 0;
  int cnt;
  logic [15:0] w1 [18] = '{16'hce1c, 16'hce1b, 16'hce25, 16'hce24, 16'hce26, 16'hce20,
    16'hce21, 16'hce36, 16'hce37, 16'hce0f, 16'hce0a, 16'h558b, 16'h4005, 16'h7b05,
    16'h3a05, 16'h8345, 16'hc9ab, 16'h0345};
  dspid_op_e k1 [18] = '{DSPID_NOP, DSPID_ACC_MAGNITUDE, DSPID_BRANCH_VIA_ACC,
    DSPID_CALL_VIA_ACC, DSPID_RETURN_OP, DSPID_TX_MODE_CLEAR, DSPID_TX_MODE_SET,
    DSPID_FRAMESYNC_MODE_CLEAR, DSPID_FRAMESYNC_MODE_SET, DSPID_SERIAL_FORMAT_SET,
    DSPID_PRODUCT_SHIFT_MODE_SET, DSPID_LOAD_AUX_POINTER, DSPID_ZERO_LOW_LOAD_HIGH,
    DSPID_ZERO_LOW_LOAD_HIGH_ROUND, DSPID_MULT_ADD_PREV, DSPID_PORT_IN,
    DSPID_PAGE_PTR_LOAD_IMM, DSPID_ADD_SHIFT};
  logic [15:0] w2 [9] = '{16'hff80, 16'h5c00, 16'hfc00, 16'hd301, 16'hd302, 16'hd303,
    16'hd304, 16'hd305, 16'hd306};
  dspid_op_e k2 [9] = '{DSPID_BRANCH, DSPID_MULT_ACC_MOVE, DSPID_BLOCK_MOVE_PROG_TO_DATA,
    DSPID_LOAD_LONG_IMM, DSPID_ACC_ADD_LONG_IMM, DSPID_SUB_LONG_IMM, DSPID_AND_LONG_IMM,
    DSPID_OR_LONG_IMM, DSPID_XOR_LONG_IMM};
  dspid_decoder i_dut (.clk_sys, .rst, .instr_word, .instr_valid, .acc_zero, .acc_neg,
    .acc_ovf, .acc_carry, .acc_msb_equal, .ar_cur_val, .ar0_val, .bio_n_pin, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .op_valid, .op_kind, .two_word, .fetch_second,
    .fetch_stall, .shift_code, .store_shift, .aux_sel, .cmp_mode, .port_addr_field,
    .imm_word, .data_addr, .ind_mode, .ind_ctrl, .pc_load, .pc_target, .pc_from_acc,
    .push_return, .pop_return, .acc_normalize_shift, .aux_reg_pointer, .product_shift_mode,
    .serial_format, .tx_mode, .framesync_mode, .test_control_flag, .page_ptr);
  dspid_datapath_model i_dp (.clk_sys, .acc_in, .ovf_in, .carry_in, .acc_zero, .acc_neg,
    .acc_ovf, .acc_carry, .acc_msb_equal);
  // 25 MHz system clock
  always #20 clk_sys = ~clk_sys;
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // one instruction word, outputs settled on return
  task automatic issue(input logic [15:0] w);
    @(posedge clk_sys);
    instr_word <= w;
    instr_valid <= 1'b1;
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", e, reg_rdata);
  endtask
  // conditional branch with given flags, checks whether it is taken
  task automatic br(input logic [31:0] a, input logic b, input logic [15:0] w, input logic e);
    @(posedge clk_sys);
    acc_in <= a;
    bio_n_pin <= b;
    issue(w);
    issue(16'h4321);
    chk("pc_load", {15'h0, e}, {15'h0, pc_load});
  endtask
  task automatic nm(input logic [31:0] a, input logic e);
    @(posedge clk_sys);
    acc_in <= a;
    issue(16'hce80);
    chk("acc_normalize_shift", {15'h0, e}, {15'h0, acc_normalize_shift});
    chk("test_control_flag", {15'h0, !e}, {15'h0, test_control_flag});
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // hang guard, far beyond the fewer than two hundred cycles of the run
  initial begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    finish_test;
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    rd(4'h0, 16'h0001);
    rd(4'h1, 16'h0000);
    wr(4'hf, 16'hffff);
    rd(4'hf, 16'h0000);
    for (int i = 0; i < 18; i++) begin
      issue(w1[i]);
      chk("op_valid", 16'h0001, {15'h0, op_valid});
      chk("op_kind", {10'h0, k1[i]}, {10'h0, op_kind});
    end
    chk("data_addr", 16'hd5c5, data_addr);
    chk("shift_code", 16'h0003, {12'h0, shift_code});
    chk("tx_mode", 16'h0001, {15'h0, tx_mode});
    chk("framesync_mode", 16'h0001, {15'h0, framesync_mode});
    chk("serial_format", 16'h0001, {15'h0, serial_format});
    chk("product_shift_mode", 16'h0002, {14'h0, product_shift_mode});
    chk("aux_reg_pointer", 16'h0003, {13'h0, aux_reg_pointer});
    rd(4'h1, 16'h01ab);
    rd(4'h2, 16'h0743);
    wr(4'h1, 16'h0002);
    issue(16'h0045);
    chk("data_addr", 16'h0145, data_addr);
    chk("ind_ctrl", 16'h0045, {9'h0, ind_ctrl});
    issue(16'h6d80);
    chk("store_shift", 16'h0005, {13'h0, store_shift});
    chk("ind_mode", 16'h0001, {15'h0, ind_mode});
    issue(16'h3600);
    chk("aux_sel", 16'h0006, {13'h0, aux_sel});
    issue(16'he745);
    chk("port_addr_field", 16'h0007, {12'h0, port_addr_field});
    @(posedge clk_sys);
    ar_cur_val <= 16'h0005;
    ar0_val <= 16'h0005;
    for (int m = 0; m < 4; m++) begin
      issue(16'hce50 + 16'(m));
      chk("test_control_flag", {15'h0, m == 0}, {15'h0, test_control_flag});
      chk("cmp_mode", 16'(m), {14'h0, cmp_mode});
    end
    @(posedge clk_sys);
    ar_cur_val <= 16'h0003;
    issue(16'hce51);
    chk("test_control_flag", 16'h0001, {15'h0, test_control_flag});
    nm(32'h0000_0001, 1'b1);
    nm(32'h4000_0000, 1'b0);
    for (int i = 0; i < 9; i++) begin
      issue(w2[i]);
      chk("fetch_second", 16'h0001, {15'h0, fetch_second});
      issue(16'h1230 + 16'(i));
      chk("op_kind", {10'h0, k2[i]}, {10'h0, op_kind});
      chk("imm_word", 16'h1230 + 16'(i), imm_word);
      chk("two_word", 16'h0001, {15'h0, two_word});
    end
    chk("shift_code", 16'h0003, {12'h0, shift_code});
    br(32'h0000_0000, 1'b1, 16'hf680, 1'b1);
    br(32'h0000_0001, 1'b1, 16'hf680, 1'b0);
    br(32'h0000_0001, 1'b0, 16'hfa80, 1'b1);
    br(32'h0000_0001, 1'b1, 16'hfa80, 1'b0);
    br(32'h0000_0001, 1'b1, 16'h5f80, 1'b1);
    wr(4'h3, 16'h0002);
    issue(16'hce1b);
    chk("fetch_stall", 16'h0001, {15'h0, fetch_stall});
    cnt = int'(op_valid);
    repeat (4) begin
      @(posedge clk_sys);
      #1;
      cnt += int'(op_valid);
    end
    chk("repeat pulses", 16'h0003, 16'(cnt));
    rd(4'h3, 16'h0000);
    wr(4'h0, 16'h0000);
    issue(16'hce24);
    chk("op_valid", 16'h0000, {15'h0, op_valid});
    rd(4'h4, 16'hce1b);
    finish_test;
  end
endmodule
